// ==== hw/reset_mode_pin_control.sv ====
// reset and mode pin control: shared reset pin, reset stretch, reset cause,
// debug/mode pin sampling and general port pin options behind AXI4-Lite
// assumes srst is the power-on reset and all other inputs but the pins are
// on the bus clock; the background debug controller itself lives outside
`timescale 1ns/100ps

module reset_mode_pin_control #(
  parameter int PORT_WIDTH = 8,
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // port pins, two-way
  input wire logic [PORT_WIDTH-1:0] port_pin_in,
  output logic [PORT_WIDTH-1:0] port_pin_out,
  output logic [PORT_WIDTH-1:0] port_pin_oe,
  output logic [PORT_WIDTH-1:0] port_pin_pullup,
  output logic [PORT_WIDTH-1:0] port_pin_drive_high,
  output logic [PORT_WIDTH-1:0] port_pin_slew_enable,
  // peripherals that may own pins
  input wire logic [PORT_WIDTH-1:0] peripheral_select,
  input wire logic [PORT_WIDTH-1:0] peripheral_oe,
  input wire logic [PORT_WIDTH-1:0] peripheral_out,
  // background debug controller side
  input wire logic debug_drive_low,
  input wire logic debug_speedup,
  output logic debug_pin_level,
  output logic debug_bit_strobe,
  // internal reset sources and system outputs
  input wire logic internal_reset_request,
  output logic system_reset,
  output logic background_mode,
  output logic clock_source_internal
);

  localparam int W = PORT_WIDTH;
  localparam logic [reset_mode_pin_pkg::COUNT_WIDTH-1:0] STRETCH_LOAD =
    reset_mode_pin_pkg::COUNT_WIDTH'(reset_mode_pin_pkg::STRETCH_CYCLES
                                      + reset_mode_pin_pkg::SETTLE_CYCLES);
  localparam logic [reset_mode_pin_pkg::COUNT_WIDTH-1:0] SETTLE_LOAD =
    reset_mode_pin_pkg::COUNT_WIDTH'(reset_mode_pin_pkg::SETTLE_CYCLES);
  localparam logic [3:0] DEBUG_BIT_LAST =
    4'(reset_mode_pin_pkg::DEBUG_BIT_CYCLES - 1);

  // pin synchronisers
  logic [W-1:0] pin_meta_reg;
  logic [W-1:0] pin_sync_reg;

  // registers
  logic reset_pin_enable_reg;
  logic [1:0] reset_pin_armed_reg;
  logic debug_pin_enable_reg;
  logic ext_clock_select_reg;
  logic [7:0] cause_reg;
  logic [W-1:0] data_reg;
  logic [W-1:0] direction_reg;
  logic [W-1:0] pullup_reg;
  logic [W-1:0] drive_reg;
  logic [W-1:0] slew_reg;
  logic [W-1:0] gang_reg;
  logic background_mode_reg;
  logic sample_pending_reg;
  logic [reset_mode_pin_pkg::COUNT_WIDTH-1:0] count_reg;
  logic [reset_mode_pin_pkg::COUNT_WIDTH-1:0] count_next;
  logic [3:0] bit_count_reg;

  // bus state
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // bus decode
  wire write_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  wire read_fire = s_axi_arvalid & ~rvalid_reg;
  wire [7:0] waddr = s_axi_awaddr[7:0];
  wire [7:0] raddr = s_axi_araddr[7:0];
  wire write_lane = write_fire & s_axi_wstrb[0];
  wire wr_options = write_lane & (waddr == reset_mode_pin_pkg::SYSTEM_OPTIONS_ONE_OFFSET);
  wire wr_force = write_lane & (waddr == reset_mode_pin_pkg::DEBUG_FORCE_RESET_OFFSET);
  wire wr_data = write_lane & (waddr == reset_mode_pin_pkg::PORT_DATA_OFFSET);
  wire wr_direction = write_lane & (waddr == reset_mode_pin_pkg::PORT_DIRECTION_OFFSET);
  wire wr_pullup = write_lane & (waddr == reset_mode_pin_pkg::PORT_PULLUP_OFFSET);
  wire wr_drive = write_lane & (waddr == reset_mode_pin_pkg::PORT_DRIVE_OFFSET);
  wire wr_slew = write_lane & (waddr == reset_mode_pin_pkg::PORT_SLEW_OFFSET);
  wire wr_gang = write_lane & (waddr == reset_mode_pin_pkg::PORT_GANG_OFFSET);
  // registers sit at every word from zero up to the status register
  wire waddr_mapped = (waddr[1:0] == 2'h0) &
    (waddr <= reset_mode_pin_pkg::MODE_STATUS_OFFSET);

  // reset sequencing
  wire reset_busy = (count_reg != '0);
  wire pin_reset_request =
    reset_pin_armed_reg[1] & ~pin_sync_reg[reset_mode_pin_pkg::RESET_PIN_INDEX];
  wire force_request = wr_force & s_axi_wdata[reset_mode_pin_pkg::FORCE_BIT];
  // requests are ignored while a reset runs, so our own low drive on the pin
  // and its synchroniser delay cannot retrigger a further reset
  wire soft_reset = ~reset_busy & (pin_reset_request | internal_reset_request | force_request);
  wire any_reset = srst | soft_reset;
  wire reset_drive_low = reset_pin_enable_reg & (count_reg > SETTLE_LOAD);
  wire reset_release = (count_reg == 7'h01);

  wire [7:0] soft_cause;
  assign soft_cause[reset_mode_pin_pkg::CAUSE_POR_BIT] = 1'b0;
  assign soft_cause[reset_mode_pin_pkg::CAUSE_PIN_BIT] = pin_reset_request;
  assign soft_cause[reset_mode_pin_pkg::CAUSE_INTERNAL_BIT] = internal_reset_request;
  assign soft_cause[4:2] = 3'h0;
  assign soft_cause[reset_mode_pin_pkg::CAUSE_DEBUG_BIT] = force_request;
  assign soft_cause[0] = 1'b0;

  always_comb begin
    if (soft_reset) begin
      count_next = STRETCH_LOAD;
    end else if (reset_busy) begin
      count_next = count_reg - 7'h01;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge clock) begin
    pin_meta_reg <= port_pin_in;
    pin_sync_reg <= pin_meta_reg;
  end

  // power-on reset loads only the settle count: synchronisers fill before
  // the mode pin is sampled, and the reset pin is not driven
  always_ff @(posedge clock) begin
    if (srst) begin
      count_reg <= SETTLE_LOAD;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cause_reg <= reset_mode_pin_pkg::CAUSE_AFTER_POR;
    end else if (soft_reset) begin
      cause_reg <= soft_cause;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reset_pin_enable_reg <= 1'b0;
    end else if (wr_options & s_axi_wdata[reset_mode_pin_pkg::OPT_RESET_PIN_BIT]) begin
      reset_pin_enable_reg <= 1'b1;
    end
  end

  // the synchronised level is trusted only two edges after the pull-up
  // comes on, so a floating pin cannot fake a reset at enable time
  always_ff @(posedge clock) begin
    if (srst) begin
      reset_pin_armed_reg <= 2'h0;
    end else begin
      reset_pin_armed_reg <= {reset_pin_armed_reg[0], reset_pin_enable_reg};
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      debug_pin_enable_reg <= 1'b1;
      ext_clock_select_reg <= 1'b0;
    end else if (wr_options) begin
      debug_pin_enable_reg <= s_axi_wdata[reset_mode_pin_pkg::OPT_DEBUG_PIN_BIT];
      ext_clock_select_reg <= s_axi_wdata[reset_mode_pin_pkg::OPT_EXT_CLOCK_BIT];
    end
  end

  // mode pin is read at the release of a power-on or forced reset only
  always_ff @(posedge clock) begin
    if (srst) begin
      sample_pending_reg <= 1'b1;
    end else if (soft_reset) begin
      sample_pending_reg <= force_request;
    end else if (reset_release) begin
      sample_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      background_mode_reg <= 1'b0;
    end else if (reset_release & sample_pending_reg) begin
      background_mode_reg <= ~pin_sync_reg[reset_mode_pin_pkg::DEBUG_PIN_INDEX];
    end
  end

  always_ff @(posedge clock) begin
    if (any_reset) begin
      data_reg <= W'(reset_mode_pin_pkg::PORT_REG_RESET);
      direction_reg <= W'(reset_mode_pin_pkg::PORT_REG_RESET);
      pullup_reg <= W'(reset_mode_pin_pkg::PORT_REG_RESET);
      drive_reg <= W'(reset_mode_pin_pkg::PORT_REG_RESET);
      slew_reg <= W'(reset_mode_pin_pkg::PORT_REG_RESET);
      gang_reg <= W'(reset_mode_pin_pkg::PORT_REG_RESET);
    end else begin
      if (wr_data) data_reg <= s_axi_wdata[W-1:0];
      if (wr_direction) direction_reg <= s_axi_wdata[W-1:0];
      if (wr_pullup) pullup_reg <= s_axi_wdata[W-1:0];
      if (wr_drive) drive_reg <= s_axi_wdata[W-1:0];
      if (wr_slew) slew_reg <= s_axi_wdata[W-1:0];
      if (wr_gang) gang_reg <= s_axi_wdata[W-1:0];
    end
  end

  // bit-time strobe for the debug controller while the debug pin is enabled
  always_ff @(posedge clock) begin
    if (any_reset | ~debug_pin_enable_reg | (bit_count_reg == DEBUG_BIT_LAST)) begin
      bit_count_reg <= 4'h0;
    end else begin
      bit_count_reg <= bit_count_reg + 4'h1;
    end
  end

  // write channel: address and data are taken together, response follows
  always_ff @(posedge clock) begin
    if (srst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= reset_mode_pin_pkg::RESP_OKAY;
    end else if (write_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= waddr_mapped ? reset_mode_pin_pkg::RESP_OKAY
                                : reset_mode_pin_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel
  wire [W-1:0] port_read_value;
  wire [7:0] options_value;
  wire [7:0] status_value;
  assign options_value = {5'h00, ext_clock_select_reg, debug_pin_enable_reg,
                          reset_pin_enable_reg};
  assign status_value = {5'h00, ~ext_clock_select_reg, system_reset, background_mode_reg};
  wire [31:0] options_word = 32'(options_value);
  wire [31:0] cause_word = 32'(cause_reg);
  wire [31:0] status_word = 32'(status_value);
  wire [31:0] data_word = 32'(port_read_value);
  wire [31:0] direction_word = 32'(direction_reg);
  wire [31:0] pullup_word = 32'(pullup_reg);
  wire [31:0] drive_word = 32'(drive_reg);
  wire [31:0] slew_word = 32'(slew_reg);
  wire [31:0] gang_word = 32'(gang_reg);
  wire [31:0] read_value =
    (raddr == reset_mode_pin_pkg::SYSTEM_OPTIONS_ONE_OFFSET) ? options_word :
    (raddr == reset_mode_pin_pkg::RESET_CAUSE_OFFSET) ? cause_word :
    (raddr == reset_mode_pin_pkg::PORT_DATA_OFFSET) ? data_word :
    (raddr == reset_mode_pin_pkg::PORT_DIRECTION_OFFSET) ? direction_word :
    (raddr == reset_mode_pin_pkg::PORT_PULLUP_OFFSET) ? pullup_word :
    (raddr == reset_mode_pin_pkg::PORT_DRIVE_OFFSET) ? drive_word :
    (raddr == reset_mode_pin_pkg::PORT_SLEW_OFFSET) ? slew_word :
    (raddr == reset_mode_pin_pkg::PORT_GANG_OFFSET) ? gang_word :
    (raddr == reset_mode_pin_pkg::MODE_STATUS_OFFSET) ? status_word : 32'h00000000;
  wire raddr_mapped = (raddr[1:0] == 2'h0) &
    (raddr <= reset_mode_pin_pkg::MODE_STATUS_OFFSET);

  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= reset_mode_pin_pkg::RESP_OKAY;
    end else if (read_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= read_value;
      rresp_reg <= raddr_mapped ? reset_mode_pin_pkg::RESP_OKAY
                                : reset_mode_pin_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // per-pin muxing: dedicated reset/debug function first, then ganged
  // output, then a peripheral, then the port registers
  wire gang_data = data_reg[reset_mode_pin_pkg::GANG_SOURCE_INDEX];
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_pin
      wire gpio_oe = gang_reg[i] | (peripheral_select[i] ? peripheral_oe[i]
                                                         : direction_reg[i]);
      wire gpio_out = gang_reg[i] ? gang_data :
                      (peripheral_select[i] ? peripheral_out[i] : data_reg[i]);
      wire gpio_pullup = pullup_reg[i] & ~gpio_oe;
      // the read source follows direction even when a peripheral owns the pin
      assign port_read_value[i] = direction_reg[i] ? data_reg[i] : pin_sync_reg[i];
      if (i == reset_mode_pin_pkg::RESET_PIN_INDEX) begin : g_reset
        // open drain while reset_pin_enable_reg is set: then only ever drives low
        assign port_pin_oe[i] = reset_pin_enable_reg ? reset_drive_low : gpio_oe;
        assign port_pin_out[i] = reset_pin_enable_reg ? 1'b0 : gpio_out;
        assign port_pin_pullup[i] = reset_pin_enable_reg | gpio_pullup;
      end else if (i == reset_mode_pin_pkg::DEBUG_PIN_INDEX) begin : g_debug
        // pseudo open drain with driven high speedup pulses
        assign port_pin_oe[i] = debug_pin_enable_reg ? (debug_drive_low | debug_speedup)
                                                     : gpio_oe;
        assign port_pin_out[i] = debug_pin_enable_reg ? debug_speedup : gpio_out;
        assign port_pin_pullup[i] = debug_pin_enable_reg | gpio_pullup;
      end else begin : g_plain
        assign port_pin_oe[i] = gpio_oe;
        assign port_pin_out[i] = gpio_out;
        assign port_pin_pullup[i] = gpio_pullup;
      end
    end
  endgenerate

  // ganged pins follow the source pin's drive and slew settings
  assign port_pin_drive_high = (drive_reg & ~gang_reg) |
    ({W{drive_reg[reset_mode_pin_pkg::GANG_SOURCE_INDEX]}} & gang_reg);
  assign port_pin_slew_enable = (slew_reg & ~gang_reg) |
    ({W{slew_reg[reset_mode_pin_pkg::GANG_SOURCE_INDEX]}} & gang_reg);

  assign debug_pin_level = pin_sync_reg[reset_mode_pin_pkg::DEBUG_PIN_INDEX];
  assign debug_bit_strobe = debug_pin_enable_reg & (bit_count_reg == DEBUG_BIT_LAST);
  assign system_reset = srst | reset_busy;
  assign background_mode = background_mode_reg;
  assign clock_source_internal = ~ext_clock_select_reg;

  assign s_axi_awready = write_fire;
  assign s_axi_wready = write_fire;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule // reset_mode_pin_control

// ==== inc/reset_mode_pin_pkg.sv ====
// constants shared by the reset and mode pin control block
// assumes a 32-bit AXI4-Lite register bus and one bus clock domain
package reset_mode_pin_pkg;

  // register byte offsets
  localparam logic [7:0] SYSTEM_OPTIONS_ONE_OFFSET = 8'h00;
  localparam logic [7:0] RESET_CAUSE_OFFSET = 8'h04;
  localparam logic [7:0] DEBUG_FORCE_RESET_OFFSET = 8'h08;
  localparam logic [7:0] PORT_DATA_OFFSET = 8'h0c;
  localparam logic [7:0] PORT_DIRECTION_OFFSET = 8'h10;
  localparam logic [7:0] PORT_PULLUP_OFFSET = 8'h14;
  localparam logic [7:0] PORT_DRIVE_OFFSET = 8'h18;
  localparam logic [7:0] PORT_SLEW_OFFSET = 8'h1c;
  localparam logic [7:0] PORT_GANG_OFFSET = 8'h20;
  localparam logic [7:0] MODE_STATUS_OFFSET = 8'h24;

  // system_options_one fields
  localparam int OPT_RESET_PIN_BIT = 0;
  localparam int OPT_DEBUG_PIN_BIT = 1;
  localparam int OPT_EXT_CLOCK_BIT = 2;

  // reset_cause_register fields
  localparam int CAUSE_DEBUG_BIT = 1;
  localparam int CAUSE_INTERNAL_BIT = 5;
  localparam int CAUSE_PIN_BIT = 6;
  localparam int CAUSE_POR_BIT = 7;

  // debug_force_reset_register and mode status fields
  localparam int FORCE_BIT = 0;
  localparam int STATUS_BACKGROUND_BIT = 0;
  localparam int STATUS_RESET_BIT = 1;
  localparam int STATUS_INT_CLOCK_BIT = 2;

  // values after reset
  localparam logic [7:0] CAUSE_AFTER_POR = 8'h80;
  localparam logic [7:0] PORT_REG_RESET = 8'h00;

  // cycle counts on the bus clock
  localparam int STRETCH_CYCLES = 66;
  localparam int SETTLE_CYCLES = 3;
  localparam int DEBUG_BIT_CYCLES = 16;
  localparam int COUNT_WIDTH = 7;

  // pin positions inside the port
  localparam int DEBUG_PIN_INDEX = 4;
  localparam int RESET_PIN_INDEX = 5;
  localparam int GANG_SOURCE_INDEX = 0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verification/reset_mode_pin_assertions.sv ====
// checker for the reset and mode pin control block, ports only
// assumes it is bound onto every reset_mode_pin_control instance
`timescale 1ns/100ps
module reset_mode_pin_assertions #(
  parameter int PORT_WIDTH = 8,
  parameter int ADDR_WIDTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [PORT_WIDTH-1:0] port_pin_oe,
  input wire logic [PORT_WIDTH-1:0] port_pin_out,
  input wire logic [PORT_WIDTH-1:0] port_pin_pullup,
  input wire logic debug_speedup,
  input wire logic debug_bit_strobe,
  input wire logic internal_reset_request,
  input wire logic system_reset,
  input wire logic background_mode,
  input wire logic clock_source_internal
);
  localparam int RP = reset_mode_pin_pkg::RESET_PIN_INDEX;
  localparam int DP = reset_mode_pin_pkg::DEBUG_PIN_INDEX;
  logic [7:0] low_count_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // the stretch is longer than any legal repetition, so it is counted here
  always_ff @(posedge clock) begin
    if (srst || !port_pin_oe[RP])
      low_count_reg <= 8'h00;
    else
      low_count_reg <= low_count_reg + 8'h01;
  end
  AST_POR_STATE: assert property ($fell(srst) |-> clock_source_internal &&
    !port_pin_oe[RP] && !port_pin_pullup[RP] && port_pin_pullup[DP])
    else $error("bad por pin state");
  AST_SOFT_RELEASE: assert property ($fell(system_reset) |->
    clock_source_internal && port_pin_pullup[DP]) else $error("bad release state");
  AST_STRETCH_LENGTH: assert property ($fell(port_pin_oe[RP]) && system_reset |->
    low_count_reg == reset_mode_pin_pkg::STRETCH_CYCLES) else $error("bad stretch");
  AST_STRETCH_TAIL: assert property ($fell(port_pin_oe[RP]) && system_reset |->
    system_reset[*3] ##1 !system_reset) else $error("bad reset tail");
  AST_OPEN_DRAIN: assert property (port_pin_oe[RP] && system_reset |-> !port_pin_out[RP])
    else $error("reset pin high");
  AST_INTERNAL_RESET: assert property (internal_reset_request && !system_reset |=>
    system_reset[*8]) else $error("no internal reset");
  AST_MODE_SAMPLE: assert property ($changed(background_mode) |->
    $past(system_reset) && !system_reset) else $error("stray mode change");
  AST_BIT_GAP: assert property (debug_bit_strobe |=> !debug_bit_strobe[*8])
    else $error("strobes too close");
  AST_SPEEDUP: assert property (debug_speedup && port_pin_pullup[DP] |->
    port_pin_oe[DP] && port_pin_out[DP]) else $error("speedup not high");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("late bvalid");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late rvalid");
endmodule // reset_mode_pin_assertions

bind reset_mode_pin_control reset_mode_pin_assertions #(
  .PORT_WIDTH(PORT_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)
) chk (
  .clock(clock), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .port_pin_oe(port_pin_oe), .port_pin_out(port_pin_out),
  .port_pin_pullup(port_pin_pullup), .debug_speedup(debug_speedup),
  .debug_bit_strobe(debug_bit_strobe), .internal_reset_request(internal_reset_request),
  .system_reset(system_reset), .background_mode(background_mode),
  .clock_source_internal(clock_source_internal)
);

// ==== verification/reset_mode_pin_control_bench.sv ====
// self-checking bench for reset_mode_pin_control with the pod model
// assumes the checker is bound in by its own file
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module reset_mode_pin_control_bench;
  localparam logic [7:0] OPT = reset_mode_pin_pkg::SYSTEM_OPTIONS_ONE_OFFSET;
  localparam logic [7:0] DATA = reset_mode_pin_pkg::PORT_DATA_OFFSET;
  localparam logic [7:0] DIR = reset_mode_pin_pkg::PORT_DIRECTION_OFFSET;
  localparam logic [7:0] M = 8'hcf;
  logic clock = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic dlow = 1'b0, dspd = 1'b0, ireq = 1'b0, hrst = 1'b0, hmode = 1'b0;
  logic awr, wrdy, bv, arr, rv, sys_rst, bg, dlev, dstb, clk_int;
  logic [7:0] awa = 8'h00, ara = 8'h00, psel = 8'h00, poe_p = 8'h00, pout_p = 8'h00;
  logic [7:0] ext_en = M, ext_val = 8'h00, lvl, poe, pout, ppu, pdrv, pslw;
  logic [31:0] wd = 32'h00000000, rd;
  logic [1:0] br, rr, wresp;
  int miscompares = 0, tests_run = 0;
  always #2.5 clock = ~clock;
  reset_mode_pin_control dut (
    .clock(clock), .srst(srst), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .port_pin_in(lvl), .port_pin_out(pout), .port_pin_oe(poe), .port_pin_pullup(ppu),
    .port_pin_drive_high(pdrv), .port_pin_slew_enable(pslw), .peripheral_select(psel),
    .peripheral_oe(poe_p), .peripheral_out(pout_p), .debug_drive_low(dlow),
    .debug_speedup(dspd), .debug_pin_level(dlev), .debug_bit_strobe(dstb),
    .internal_reset_request(ireq), .system_reset(sys_rst), .background_mode(bg),
    .clock_source_internal(clk_int));
  reset_mode_pin_pod pod (.clock(clock), .hold_reset(hrst), .hold_mode(hmode), .ext_en(ext_en),
    .ext_val(ext_val), .pin_oe(poe), .pin_out(pout), .pin_pullup(ppu), .pin_level(lvl));
  function automatic logic [7:0] port_exp(logic [7:0] dir, logic [7:0] dat, logic [7:0] pin);
    return (dir & dat) | (~dir & pin);
  endfunction
  function automatic logic [7:0] cause_exp(int k);
    return (k == 0) ? 8'h40 : (k == 1) ? 8'h20 : 8'h02;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(inout int n);
    n++;
    if (n > 300) begin
      $display("[ERR] wait expected answer seen none");
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= {24'h000000, d};
    do begin @(negedge clock); step(n); end while (awr !== 1'b1 || wrdy !== 1'b1);
    @(posedge clock);
    awv <= 1'b0;
    wv <= 1'b0;
    bre <= 1'b1;
    do begin @(negedge clock); step(n); end while (bv !== 1'b1);
    wresp = br;
    @(posedge clock);
    bre <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    arv <= 1'b1;
    ara <= a;
    do begin @(negedge clock); step(n); end while (arr !== 1'b1);
    @(posedge clock);
    arv <= 1'b0;
    rre <= 1'b1;
    do begin @(negedge clock); step(n); end while (rv !== 1'b1);
    d = rd[7:0];
    r = rr;
    @(posedge clock);
    rre <= 1'b0;
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a, m, e);
    logic [7:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    `CHK(nm, e & m, d & m)
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin @(negedge clock); step(n); end while (sys_rst !== 1'b0);
    @(posedge clock);
  endtask
  initial begin
    int n;
    logic [7:0] v, dir, dat, drv, slw, pu;
    logic [1:0] r;
    void'($urandom(89398));
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    wait_idle();
    `CHK("clock_internal", 1'b1, clk_int)
    `CHK("pin_oe", 8'h00, poe)
    `CHK("pin_pullup", 8'h10, ppu)
    chk_reg("options", OPT, 8'hff, 8'h02);
    chk_reg("cause", reset_mode_pin_pkg::RESET_CAUSE_OFFSET, 8'hff, 8'h80);
    rd_reg(8'h30, v, r);
    `CHK("unmapped_rresp", reset_mode_pin_pkg::RESP_SLVERR, r)
    wr_reg(8'h30, 8'hff);
    `CHK("unmapped_bresp", reset_mode_pin_pkg::RESP_SLVERR, wresp)
    for (int i = 0; i < 4; i++) begin
      dir = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      dat = 8'($urandom());
      drv = 8'($urandom());
      slw = 8'($urandom());
      pu = 8'($urandom());
      wr_reg(DIR, dir);
      wr_reg(DATA, dat);
      wr_reg(reset_mode_pin_pkg::PORT_DRIVE_OFFSET, drv);
      wr_reg(reset_mode_pin_pkg::PORT_SLEW_OFFSET, slw);
      wr_reg(reset_mode_pin_pkg::PORT_PULLUP_OFFSET, pu);
      ext_val <= 8'($urandom());
      repeat (4) @(negedge clock);
      `CHK("pin_oe", dir & M, poe & M)
      `CHK("pin_out", dat & dir & M, pout & dir & M)
      `CHK("drive", drv & M, pdrv & M)
      `CHK("slew", slw & M, pslw & M)
      `CHK("pullup", pu & ~dir & M, ppu & M)
      chk_reg("port_read", DATA, M, port_exp(dir, dat, ext_val));
    end
    v = 8'($urandom());
    wr_reg(DIR, 8'h02);
    wr_reg(DATA, ~v);
    psel <= 8'h06;
    poe_p <= 8'h02;
    pout_p <= v;
    chk_reg("periph_read", DATA, 8'h02, ~v);
    `CHK("periph_pin", {v[1], 1'b1}, {pout[1], poe[1]})
    wr_reg(DIR, 8'h00);
    chk_reg("periph_read", DATA, 8'h02, v);
    wr_reg(DATA, 8'h01);
    wr_reg(reset_mode_pin_pkg::PORT_DRIVE_OFFSET, 8'h01);
    wr_reg(reset_mode_pin_pkg::PORT_GANG_OFFSET, 8'h04);
    @(negedge clock);
    `CHK("gang", 3'b111, {poe[2], pout[2], pdrv[2]})
    @(posedge clock);
    psel <= 8'h00;
    dspd <= 1'b1;
    @(negedge clock);
    `CHK("speedup", 2'b11, {poe[4], pout[4]})
    @(posedge clock);
    dspd <= 1'b0;
    dlow <= 1'b1;
    repeat (4) @(negedge clock);
    `CHK("debug_level", 1'b0, dlev)
    @(posedge clock);
    dlow <= 1'b0;
    for (int e = 1; e >= 0; e--) begin
      n = 0;
      repeat (48) begin @(negedge clock); if (dstb === 1'b1) n++; end
      `CHK("strobes", 3 * e, n)
      wr_reg(OPT, (e == 0) ? 8'h02 : 8'h00);
      `CHK("debug_pullup", 1'(e == 0) | pu[4], ppu[4])
    end
    // the enable is sticky, so the later clear must not drop it
    wr_reg(OPT, 8'h05);
    `CHK("reset_pin", 2'b10, {ppu[5], poe[5]})
    `CHK("clock_external", 1'b0, clk_int)
    wr_reg(OPT, 8'h04);
    chk_reg("lock", OPT, 8'h01, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr_reg(OPT, 8'h05);
      hmode <= (k == 3);
      if (k == 0)
        hrst <= 1'b1;
      else if (k == 1)
        ireq <= 1'b1;
      else
        wr_reg(reset_mode_pin_pkg::DEBUG_FORCE_RESET_OFFSET, 8'h01);
      n = 0;
      do begin @(negedge clock); step(n); end while (sys_rst !== 1'b1);
      @(posedge clock);
      hrst <= 1'b0;
      ireq <= 1'b0;
      wait_idle();
      hmode <= 1'b0;
      `CHK("background", 1'(k == 3), bg)
      `CHK("clock_internal", 1'b1, clk_int)
      chk_reg("cause", reset_mode_pin_pkg::RESET_CAUSE_OFFSET, 8'hff, cause_exp(k));
      chk_reg("options", OPT, 8'h07, 8'h03);
    end
    chk_reg("status", reset_mode_pin_pkg::MODE_STATUS_OFFSET, 8'h07, 8'h05);
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    wait_idle();
    `CHK("background", 1'b0, bg)
    chk_reg("options", OPT, 8'hff, 8'h02);
    report_and_stop();
  end
endmodule // reset_mode_pin_control_bench

// ==== verification/reset_mode_pin_pod.sv ====
// external reset source, debug pod and board wiring seen by the port pins
// assumes the bench sets the levels of plain input pins through ext_en/ext_val
`timescale 1ns/100ps
module reset_mode_pin_pod #(
  parameter int PORT_WIDTH = 8
) (
  input wire logic clock,
  input wire logic hold_reset,
  input wire logic hold_mode,
  input wire logic [PORT_WIDTH-1:0] ext_en,
  input wire logic [PORT_WIDTH-1:0] ext_val,
  input wire logic [PORT_WIDTH-1:0] pin_oe,
  input wire logic [PORT_WIDTH-1:0] pin_out,
  input wire logic [PORT_WIDTH-1:0] pin_pullup,
  output logic [PORT_WIDTH-1:0] pin_level
);
  logic churn_reg = 1'b0;
  // a floating pin must not look like a stable level
  always @(posedge clock) churn_reg <= !churn_reg;
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      if (i == reset_mode_pin_pkg::RESET_PIN_INDEX && hold_reset)
        pin_level[i] = 1'b0;
      else if (i == reset_mode_pin_pkg::DEBUG_PIN_INDEX && hold_mode)
        pin_level[i] = 1'b0;
      else if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else
        pin_level[i] = pin_pullup[i] | churn_reg;
    end
  end
endmodule // reset_mode_pin_pod
